/* File: core/cwp_top.sv */
// Canvas window size, addressing mode and position registers with APB access
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
module cwp_top #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // APB slave
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   // Memory access and text engine events
   input wire logic [12:0] WIN_ORG_X,
   input wire logic GFX_WR_ADV,
   input wire logic GFX_RD_ADV,
   input wire logic TXT_ADV,
   input wire logic [5:0] TXT_STEP,
   // Canvas configuration
   output logic WIN_EN,
   output logic [13:0] WIN_WIDTH,
   output logic [13:0] WIN_HEIGHT,
   output logic CANVAS_LINEAR,
   output cwp_pkg::cwp_depth_e CANVAS_DEPTH,
   output logic MEM_WIDE,
   output logic RDBACK_READ,
   // Positions
   output logic [15:0] GFX_WR_X,
   output logic [15:0] GFX_WR_Y,
   output logic [15:0] GFX_RD_X,
   output logic [15:0] GFX_RD_Y,
   output logic [31:0] LIN_WR_ADDR,
   output logic [31:0] LIN_RD_ADDR,
   output logic [12:0] TXT_X
);

   cwp_pkg::cwp_req_s req;
   logic [15:0] aw_width;
   logic [15:0] aw_height;
   cwp_pkg::cwp_mode_s mode;
   logic [12:0] txt_x;
   logic [15:0] wr_x;
   logic [15:0] wr_y;
   logic [15:0] rd_x;
   logic [15:0] rd_y;
   logic [15:0] pos_mask;
   logic [15:0] rb_x;
   logic [15:0] rb_y;
   logic wr_pos_x;
   logic wr_pos_y;
   logic [15:0] next_pos_x;
   logic [15:0] next_pos_y;
   logic [15:0] next_pos;
   logic [15:0] next_txt;
   logic [15:0] rd_word;

   cwp_apb_slave #(
      .ADDR_W(ADDR_W)
   ) u_apb (
      .psel(PSEL),
      .penable(PENABLE),
      .pwrite(PWRITE),
      .paddr(PADDR),
      .pwdata(PWDATA),
      .pstrb(PSTRB),
      .pready(PREADY),
      .pslverr(PSLVERR),
      .req(req)
   );

   // Window size registers
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         aw_width <= cwp_pkg::CWP_RST_16;
      end else if (req.wr && (req.idx == cwp_pkg::CWP_IDX_AW_WIDTH)) begin
         aw_width <= cwp_pkg::cwp_merge(aw_width, req.wdata, req.lanes,
                                        cwp_pkg::CWP_MASK_SIZE);
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         aw_height <= cwp_pkg::CWP_RST_16;
      end else if (req.wr && (req.idx == cwp_pkg::CWP_IDX_AW_HEIGHT)) begin
         aw_height <= cwp_pkg::cwp_merge(aw_height, req.wdata, req.lanes,
                                         cwp_pkg::CWP_MASK_SIZE);
      end
   end

   // Depth and mode register; bits 7..4 are not stored
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         mode <= cwp_pkg::CWP_RST_MODE;
      end else if (req.wr && (req.idx == cwp_pkg::CWP_IDX_MODE) && req.lanes[0]) begin
         mode <= cwp_pkg::cwp_mode_s'(req.wdata[cwp_pkg::CWP_MODE_W-1:0]);
      end
   end

   // Position width follows addressing mode
   assign pos_mask = mode.linear ? cwp_pkg::CWP_MASK_LIN : cwp_pkg::CWP_MASK_POS;

   assign wr_pos_x = req.wr && (req.idx == cwp_pkg::CWP_IDX_GFX_X);
   assign wr_pos_y = req.wr && (req.idx == cwp_pkg::CWP_IDX_GFX_Y);
   assign next_pos_x = cwp_pkg::cwp_merge(wr_x, req.wdata, req.lanes, pos_mask);
   assign next_pos_y = cwp_pkg::cwp_merge(wr_y, req.wdata, req.lanes, pos_mask);
   assign next_pos = wr_pos_x ? next_pos_x : next_pos_y;

   // Host write sets both write and prefetch positions
   cwp_pos_ptr #(
      .POS_W(cwp_pkg::CWP_POS_W),
      .LIN_W(cwp_pkg::CWP_LIN_W)
   ) u_wr_ptr (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .ld_x(wr_pos_x),
      .ld_y(wr_pos_y),
      .ld_val(next_pos),
      .adv(GFX_WR_ADV),
      .linear(mode.linear),
      .wide(mode.depth[0]),
      .org_x(WIN_ORG_X),
      .win_w(aw_width[cwp_pkg::CWP_SIZE_W-1:0]),
      .x(wr_x),
      .y(wr_y)
   );

   cwp_pos_ptr #(
      .POS_W(cwp_pkg::CWP_POS_W),
      .LIN_W(cwp_pkg::CWP_LIN_W)
   ) u_rd_ptr (
      .clk(CLK_SYS),
      .rstn(RSTN),
      .ld_x(wr_pos_x),
      .ld_y(wr_pos_y),
      .ld_val(next_pos),
      .adv(GFX_RD_ADV),
      .linear(mode.linear),
      .wide(mode.depth[0]),
      .org_x(WIN_ORG_X),
      .win_w(aw_width[cwp_pkg::CWP_SIZE_W-1:0]),
      .x(rd_x),
      .y(rd_y)
   );

   // Text X position; host write beats a same-cycle advance
   assign next_txt = cwp_pkg::cwp_merge({3'h0, txt_x}, req.wdata, req.lanes,
                                        cwp_pkg::CWP_MASK_POS);

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         txt_x <= cwp_pkg::CWP_RST_16[12:0];
      end else if (req.wr && (req.idx == cwp_pkg::CWP_IDX_TEXT_X)) begin
         txt_x <= next_txt[12:0];
      end else if (TXT_ADV) begin
         txt_x <= txt_x + {7'h00, TXT_STEP};
      end
   end

   // Readback picks write or prefetch position, clipped to the mode width
   assign rb_x = (mode.rd_sel ? rd_x : wr_x) & pos_mask;
   assign rb_y = (mode.rd_sel ? rd_y : wr_y) & pos_mask;

   always_comb begin
      case (req.idx)
         cwp_pkg::CWP_IDX_AW_WIDTH: begin
            rd_word = aw_width & cwp_pkg::CWP_MASK_SIZE;
         end
         cwp_pkg::CWP_IDX_AW_HEIGHT: begin
            rd_word = aw_height & cwp_pkg::CWP_MASK_SIZE;
         end
         cwp_pkg::CWP_IDX_MODE: begin
            rd_word = {12'h000, mode};
         end
         cwp_pkg::CWP_IDX_GFX_X: begin
            rd_word = rb_x;
         end
         cwp_pkg::CWP_IDX_GFX_Y: begin
            rd_word = rb_y;
         end
         cwp_pkg::CWP_IDX_TEXT_X: begin
            rd_word = {3'h0, txt_x};
         end
         default: begin
            rd_word = cwp_pkg::CWP_RST_16;
         end
      endcase
   end

   // Read data captured in the setup cycle, held through the access phase
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         PRDATA <= cwp_pkg::CWP_RST_32;
      end else if (req.rd) begin
         PRDATA <= {16'h0000, rd_word};
      end else if (!PSEL) begin
         PRDATA <= cwp_pkg::CWP_RST_32;
      end
   end

   // Configuration outputs; window size outputs are zero while linear, register reads keep the stored size
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         WIN_EN <= 1'b0;
         WIN_WIDTH <= cwp_pkg::CWP_RST_16[13:0];
         WIN_HEIGHT <= cwp_pkg::CWP_RST_16[13:0];
      end else begin
         WIN_EN <= !mode.linear;
         WIN_WIDTH <= mode.linear ? 14'h0000 : aw_width[13:0];
         WIN_HEIGHT <= mode.linear ? 14'h0000 : aw_height[13:0];
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         CANVAS_LINEAR <= 1'b0;
         CANVAS_DEPTH <= cwp_pkg::CWP_BPP8;
         MEM_WIDE <= 1'b0;
         RDBACK_READ <= 1'b0;
      end else begin
         CANVAS_LINEAR <= mode.linear;
         CANVAS_DEPTH <= cwp_pkg::cwp_depth_of(mode.depth);
         MEM_WIDE <= mode.linear && mode.depth[0];
         RDBACK_READ <= mode.rd_sel;
      end
   end

   // Position outputs
   always_ff @(posedge CLK_SYS) begin
      if (!RSTN) begin
         GFX_WR_X <= cwp_pkg::CWP_RST_16;
         GFX_WR_Y <= cwp_pkg::CWP_RST_16;
         GFX_RD_X <= cwp_pkg::CWP_RST_16;
         GFX_RD_Y <= cwp_pkg::CWP_RST_16;
         LIN_WR_ADDR <= cwp_pkg::CWP_RST_32;
         LIN_RD_ADDR <= cwp_pkg::CWP_RST_32;
         TXT_X <= cwp_pkg::CWP_RST_16[12:0];
      end else begin
         GFX_WR_X <= wr_x & pos_mask;
         GFX_WR_Y <= wr_y & pos_mask;
         GFX_RD_X <= rd_x & pos_mask;
         GFX_RD_Y <= rd_y & pos_mask;
         LIN_WR_ADDR <= {wr_y, wr_x};
         LIN_RD_ADDR <= {rd_y, rd_x};
         TXT_X <= txt_x;
      end
   end

endmodule

/* File: core/cwp_pkg.sv */
// Shared constants, types and helpers of the canvas window and position registers
package cwp_pkg;

   // Register indices; byte address on APB is four times the index
   localparam int unsigned CWP_IDX_W = 8;
   localparam logic [7:0] CWP_IDX_AW_WIDTH = 8'h5a;
   localparam logic [7:0] CWP_IDX_AW_HEIGHT = 8'h5c;
   localparam logic [7:0] CWP_IDX_MODE = 8'h5e;
   localparam logic [7:0] CWP_IDX_GFX_X = 8'h5f;
   localparam logic [7:0] CWP_IDX_GFX_Y = 8'h61;
   localparam logic [7:0] CWP_IDX_TEXT_X = 8'h63;

   // Field widths
   localparam int unsigned CWP_SIZE_W = 14;
   localparam int unsigned CWP_POS_W = 13;
   localparam int unsigned CWP_LIN_W = 16;
   localparam int unsigned CWP_MODE_W = 4;
   localparam int unsigned CWP_STEP_W = 6;

   // Writable-bit masks of the 16-bit registers
   localparam logic [15:0] CWP_MASK_SIZE = 16'h3fff;
   localparam logic [15:0] CWP_MASK_POS = 16'h1fff;
   localparam logic [15:0] CWP_MASK_LIN = 16'hffff;

   // Reset values
   localparam logic [15:0] CWP_RST_16 = 16'h0000;
   localparam logic [3:0] CWP_RST_MODE = 4'h0;
   localparam logic [31:0] CWP_RST_32 = 32'h0000_0000;

   // Colour-depth field codes in block mode
   localparam logic [1:0] CWP_DEPTH_8 = 2'h0;
   localparam logic [1:0] CWP_DEPTH_16 = 2'h1;

   // Linear address step per access
   localparam logic [31:0] CWP_STEP_BYTE = 32'h0000_0001;
   localparam logic [31:0] CWP_STEP_HALF = 32'h0000_0002;

   typedef enum logic [1:0] {
      CWP_BPP8,
      CWP_BPP16,
      CWP_BPP24
   } cwp_depth_e;

   // Bits 3..0 of the depth and mode register
   typedef struct packed {
      logic rd_sel;
      logic linear;
      logic [1:0] depth;
   } cwp_mode_s;

   // One decoded bus request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] idx;
      logic [1:0] lanes;
      logic [15:0] wdata;
   } cwp_req_s;

   function automatic logic cwp_is_mapped(input logic [7:0] idx);
      return (idx == CWP_IDX_AW_WIDTH) || (idx == CWP_IDX_AW_HEIGHT) ||
             (idx == CWP_IDX_MODE) || (idx == CWP_IDX_GFX_X) ||
             (idx == CWP_IDX_GFX_Y) || (idx == CWP_IDX_TEXT_X);
   endfunction

   // Byte-lane merge of a write, unused bits forced to zero
   function automatic logic [15:0] cwp_merge(input logic [15:0] old, input logic [15:0] wdata,
                                             input logic [1:0] lanes, input logic [15:0] mask);
      logic [15:0] res;
      res = old;
      if (lanes[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (lanes[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res & mask;
   endfunction

   function automatic cwp_depth_e cwp_depth_of(input logic [1:0] code);
      if (code[1]) begin
         return CWP_BPP24;
      end else if (code == CWP_DEPTH_16) begin
         return CWP_BPP16;
      end
      return CWP_BPP8;
   endfunction

endpackage

/* File: core/cwp_apb_slave.sv */
// APB slave decode for the canvas window and position registers
`timescale 1ns/1ps
module cwp_apb_slave #(
   parameter int ADDR_W = 12
) (
   // APB request
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   // APB answer
   output logic pready,
   output logic pslverr,
   // Decoded request
   output cwp_pkg::cwp_req_s req
);

   logic [ADDR_W-3:0] word;
   logic mapped;

   assign word = paddr[ADDR_W-1:2];
   // Aligned word inside the 256-entry index space and on the map
   assign mapped = (paddr[1:0] == 2'h0) &&
                   ((word >> cwp_pkg::CWP_IDX_W) == '0) &&
                   cwp_pkg::cwp_is_mapped(word[7:0]);

   // Zero wait states; unmapped access ends with an error
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;

   // Writes act at the access edge, read data is captured at setup
   assign req.wr = psel && penable && pwrite && mapped;
   assign req.rd = psel && !penable && !pwrite && mapped;
   assign req.idx = word[7:0];
   assign req.lanes = pstrb[1:0];
   assign req.wdata = pwdata[15:0];

endmodule

/* File: core/cwp_pos_ptr.sv */
// Graphic position pointer: X/Y in block mode, 32-bit byte address in linear mode
`timescale 1ns/1ps
module cwp_pos_ptr #(
   parameter int POS_W = 13,
   parameter int LIN_W = 16
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Load from host writes
   input wire logic ld_x,
   input wire logic ld_y,
   input wire logic [LIN_W-1:0] ld_val,
   // Advance from the memory access engine
   input wire logic adv,
   input wire logic linear,
   input wire logic wide,
   input wire logic [POS_W-1:0] org_x,
   input wire logic [POS_W:0] win_w,
   // Pointer
   output logic [LIN_W-1:0] x,
   output logic [LIN_W-1:0] y
);

   logic [2*LIN_W-1:0] lin_next;
   logic [POS_W:0] x_inc;
   logic [POS_W:0] x_end;
   logic [LIN_W-1:0] next_x;
   logic [LIN_W-1:0] next_y;

   assign lin_next = {y, x} + (wide ? cwp_pkg::CWP_STEP_HALF : cwp_pkg::CWP_STEP_BYTE);
   assign x_inc = {1'b0, x[POS_W-1:0]} + {{POS_W{1'b0}}, 1'b1};
   assign x_end = {1'b0, org_x} + win_w;

   always_comb begin
      next_x = x;
      next_y = y;
      if (linear) begin
         // Y holds the upper half, X the lower half of the address
         {next_y, next_x} = lin_next;
      end else if ((win_w != '0) && (x_inc >= x_end)) begin
         // Window width bounds the line only in block mode
         next_x = LIN_W'(org_x);
         next_y = LIN_W'(y[POS_W-1:0] + POS_W'(1));
      end else begin
         next_x = LIN_W'(x_inc[POS_W-1:0]);
      end
   end

   // Host load takes priority over an advance in the same cycle
   always_ff @(posedge clk) begin
      if (!rstn) begin
         x <= cwp_pkg::CWP_RST_16;
      end else if (ld_x) begin
         x <= ld_val;
      end else if (adv) begin
         x <= next_x;
      end
   end

   always_ff @(posedge clk) begin
      if (!rstn) begin
         y <= cwp_pkg::CWP_RST_16;
      end else if (ld_y) begin
         y <= ld_val;
      end else if (adv) begin
         y <= next_y;
      end
   end

endmodule

/* File: test/cwp_top_props.sv */
// Port assertions of the canvas window and position registers
`timescale 1ns/1ps
module cwp_top_props #(
   parameter int ADDR_W = 12
) (
   // Clock and reset
   input wire logic CLK_SYS,
   input wire logic RSTN,
   // APB request
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0] PWDATA,
   input wire logic [3:0] PSTRB,
   // Engine events
   input wire logic TXT_ADV,
   input wire logic [5:0] TXT_STEP,
   // Outputs
   input wire logic WIN_EN,
   input wire logic [13:0] WIN_WIDTH,
   input wire logic [13:0] WIN_HEIGHT,
   input wire logic CANVAS_LINEAR,
   input wire logic MEM_WIDE,
   input wire logic RDBACK_READ,
   input wire logic [15:0] GFX_WR_X,
   input wire logic [15:0] GFX_WR_Y,
   input wire logic [31:0] LIN_WR_ADDR,
   input wire logic [12:0] TXT_X
);
   default clocking @(posedge CLK_SYS); endclocking
   default disable iff (!RSTN);
   logic wr_acc;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   property p_lin_win;
      CANVAS_LINEAR |-> WIN_WIDTH == 14'h0 && WIN_HEIGHT == 14'h0;
   endproperty
   a_lin_win: assert property (p_lin_win) else $error("window size kept");
   property p_blk_en;
      $past(RSTN) |-> WIN_EN == !CANVAS_LINEAR;
   endproperty
   a_blk_en: assert property (p_blk_en) else $error("window enable wrong");
   property p_wide;
      MEM_WIDE |-> CANVAS_LINEAR;
   endproperty
   a_wide: assert property (p_wide) else $error("wide access in block mode");
   property p_lin_addr;
      CANVAS_LINEAR |-> LIN_WR_ADDR == {GFX_WR_Y, GFX_WR_X};
   endproperty
   a_lin_addr: assert property (p_lin_addr) else $error("linear address wrong");
   property p_blk_mask;
      !CANVAS_LINEAR |-> GFX_WR_X[15:13] == 3'h0 && GFX_WR_Y[15:13] == 3'h0;
   endproperty
   a_blk_mask: assert property (p_blk_mask) else $error("position too wide");
   property p_wr_width;
      wr_acc && PADDR == ADDR_W'({cwp_pkg::CWP_IDX_AW_WIDTH, 2'b00}) && PSTRB[1:0] == 2'h3
         && !CANVAS_LINEAR |-> ##2 WIN_WIDTH == 14'($past(PWDATA, 2));
   endproperty
   a_wr_width: assert property (p_wr_width) else $error("width not loaded");
   property p_mode_wr;
      wr_acc && PADDR == ADDR_W'({cwp_pkg::CWP_IDX_MODE, 2'b00}) && PSTRB[0]
         |-> ##2 {RDBACK_READ, CANVAS_LINEAR} == 2'($past(PWDATA, 2) >> 2);
   endproperty
   a_mode_wr: assert property (p_mode_wr) else $error("mode bits not loaded");
   property p_txt_adv;
      TXT_ADV && !$past(TXT_ADV) && !wr_acc
         |-> ##2 TXT_X == 13'($past(TXT_X) + $past(TXT_STEP, 2));
   endproperty
   a_txt_adv: assert property (p_txt_adv) else $error("text advance wrong");
   c_adv: cover property (TXT_ADV);
   c_lin: cover property (CANVAS_LINEAR && MEM_WIDE);
   c_byte: cover property (wr_acc && PSTRB == 4'h1);
endmodule
bind cwp_top cwp_top_props #(.ADDR_W(ADDR_W)) u_props (
   .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
   .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .TXT_ADV(TXT_ADV), .TXT_STEP(TXT_STEP),
   .WIN_EN(WIN_EN), .WIN_WIDTH(WIN_WIDTH), .WIN_HEIGHT(WIN_HEIGHT),
   .CANVAS_LINEAR(CANVAS_LINEAR), .MEM_WIDE(MEM_WIDE), .RDBACK_READ(RDBACK_READ),
   .GFX_WR_X(GFX_WR_X), .GFX_WR_Y(GFX_WR_Y), .LIN_WR_ADDR(LIN_WR_ADDR), .TXT_X(TXT_X)
);

/* File: test/cwp_host_model.sv */
// APB host that issues register transfers
`timescale 1ns/1ps
module cwp_host_model #(
   parameter int ADDR_W = 12
) (
   // Clock
   input wire logic clk,
   // APB request
   output logic psel,
   output logic penable,
   output logic pwrite,
   output logic [ADDR_W-1:0] paddr,
   output logic [31:0] pwdata,
   output logic [3:0] pstrb,
   // APB answer
   input wire logic pready
);
   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = '0;
      pwdata = '0;
      pstrb = 4'h0;
   end
   task automatic xfer(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                       input logic [3:0] s);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      psel <= 1'b0;
      penable <= 1'b0;
      // Released address and data lines carry junk, not the old value
      paddr <= ~a;
      pwdata <= ~d;
   endtask
endmodule

/* File: test/tb_canvas_window_position_regs.sv */
// Self-checking bench of the canvas window and position registers
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s exp %h got %h", n, e, g); end end
module tb_canvas_window_position_regs;
   typedef struct packed {
      logic rd;
      logic err;
      logic [31:0] d;
   } cwp_exp_s;
   logic CLK_SYS, RSTN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, TXT_ADV, GFX_WR_ADV;
   logic GFX_RD_ADV;
   logic [31:0] LIN_RD_ADDR;
   logic [11:0] PADDR;
   logic [31:0] PWDATA, PRDATA, LIN_WR_ADDR;
   logic [3:0] PSTRB;
   logic [5:0] TXT_STEP, st;
   logic WIN_EN, CANVAS_LINEAR, MEM_WIDE, RDBACK_READ;
   logic [13:0] WIN_WIDTH, WIN_HEIGHT;
   cwp_pkg::cwp_depth_e CANVAS_DEPTH;
   logic [15:0] GFX_WR_X, GFX_WR_Y, w, v, x, y;
   logic [12:0] TXT_X;
   logic [31:0] a;
   int seed, miscompares, num_checks;
   cwp_exp_s q[$];
   cwp_exp_s e;
   logic [7:0] pos[3] = '{cwp_pkg::CWP_IDX_GFX_X, cwp_pkg::CWP_IDX_GFX_Y, cwp_pkg::CWP_IDX_TEXT_X};
   initial begin
      CLK_SYS = 1'b0;
      forever #2.5 CLK_SYS = ~CLK_SYS;
   end
   cwp_top u_dut (
      .CLK_SYS(CLK_SYS), .RSTN(RSTN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
      .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .WIN_ORG_X(13'h0), .GFX_WR_ADV(GFX_WR_ADV), .GFX_RD_ADV(GFX_RD_ADV),
      .TXT_ADV(TXT_ADV), .TXT_STEP(TXT_STEP), .WIN_EN(WIN_EN), .WIN_WIDTH(WIN_WIDTH),
      .WIN_HEIGHT(WIN_HEIGHT), .CANVAS_LINEAR(CANVAS_LINEAR), .CANVAS_DEPTH(CANVAS_DEPTH),
      .MEM_WIDE(MEM_WIDE), .RDBACK_READ(RDBACK_READ), .GFX_WR_X(GFX_WR_X),
      .GFX_WR_Y(GFX_WR_Y), .GFX_RD_X(), .GFX_RD_Y(), .LIN_WR_ADDR(LIN_WR_ADDR),
      .LIN_RD_ADDR(LIN_RD_ADDR), .TXT_X(TXT_X)
   );
   cwp_host_model u_host (
      .clk(CLK_SYS), .psel(PSEL), .penable(PENABLE), .pwrite(PWRITE), .paddr(PADDR),
      .pwdata(PWDATA), .pstrb(PSTRB), .pready(PREADY)
   );
   task automatic wr(input logic [7:0] i, input logic [15:0] d, input logic [3:0] s = 4'h3);
      q.push_back('{1'b0, 1'b0, 32'h0});
      u_host.xfer(1'b1, {2'b00, i, 2'b00}, {16'h0, d}, s);
   endtask
   task automatic rd(input logic [7:0] i, input logic [31:0] d, input logic r = 1'b0);
      q.push_back('{1'b1, r, d});
      u_host.xfer(1'b0, {2'b00, i, 2'b00}, 32'h0, 4'h0);
   endtask
   task automatic pulse_adv(input logic txt);
      TXT_ADV <= txt;
      GFX_WR_ADV <= !txt;
      @(posedge CLK_SYS);
      TXT_ADV <= 1'b0;
      GFX_WR_ADV <= 1'b0;
   endtask
   // Each completed transfer takes the oldest expectation
   always @(posedge CLK_SYS) begin
      if (PSEL && PENABLE && PREADY) begin
         e = q.pop_front();
         `CHK("pslverr", e.err, PSLVERR);
         if (e.rd) `CHK("prdata", e.d, PRDATA);
      end
   end
   task automatic test_done();
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   initial begin
      repeat (5000) @(posedge CLK_SYS);
      miscompares++;
      test_done();
   end
   initial begin
      seed = 56945;
      RSTN = 1'b0;
      TXT_ADV = 1'b0;
      GFX_WR_ADV = 1'b0;
      GFX_RD_ADV = 1'b0;
      TXT_STEP = 6'h0;
      repeat (16) @(posedge CLK_SYS);
      RSTN <= 1'b1;
      foreach (pos[i]) rd(pos[i], 32'h0);
      // Width in range with origin zero
      w = 16'($random(seed)) | 16'hc000;
      w[13] = 1'b0;
      wr(cwp_pkg::CWP_IDX_AW_WIDTH, w);
      wr(cwp_pkg::CWP_IDX_AW_HEIGHT, 16'he000);
      rd(cwp_pkg::CWP_IDX_AW_WIDTH, {18'h0, w[13:0]});
      rd(cwp_pkg::CWP_IDX_AW_HEIGHT, 32'h2000);
      `CHK("win_height", 14'h2000, WIN_HEIGHT);
      for (int m = 0; m < 16; m++) begin
         wr(cwp_pkg::CWP_IDX_MODE, 16'hfff0 | 16'(m), 4'h1);
         rd(cwp_pkg::CWP_IDX_MODE, 32'(m));
         `CHK("linear", m[2], CANVAS_LINEAR);
         `CHK("rdback", m[3], RDBACK_READ);
         `CHK("wide", m[2] & m[0], MEM_WIDE);
         `CHK("win_w", m[2] ? 14'h0 : w[13:0], WIN_WIDTH);
         if (!m[2]) `CHK("depth", m[1] ? 2'h2 : {1'b0, m[0]}, CANVAS_DEPTH);
      end
      wr(cwp_pkg::CWP_IDX_MODE, 16'h0, 4'h1);
      foreach (pos[i]) begin
         v = 16'($random(seed));
         wr(pos[i], v);
         rd(pos[i], {19'h0, v[12:0]});
      end
      st = 6'($random(seed));
      TXT_STEP <= st;
      pulse_adv(1'b1);
      rd(cwp_pkg::CWP_IDX_TEXT_X, {19'h0, 13'(v[12:0] + st)});
      `CHK("txt_x", 13'(v[12:0] + st), TXT_X);
      wr(cwp_pkg::CWP_IDX_MODE, 16'h5, 4'h1);
      x = 16'($random(seed));
      y = 16'($random(seed));
      wr(cwp_pkg::CWP_IDX_GFX_X, x);
      wr(cwp_pkg::CWP_IDX_GFX_Y, y);
      rd(cwp_pkg::CWP_IDX_GFX_Y, {16'h0, y});
      `CHK("lin_addr", {y, x}, LIN_WR_ADDR);
      a = {y, x} + 32'h2;
      pulse_adv(1'b0);
      rd(cwp_pkg::CWP_IDX_GFX_X, {16'h0, a[15:0]});
      `CHK("lin_adv", a, LIN_WR_ADDR);
      wr(cwp_pkg::CWP_IDX_MODE, 16'hd, 4'h1);
      rd(cwp_pkg::CWP_IDX_GFX_X, {16'h0, x});
      `CHK("lin_rd", {y, x}, LIN_RD_ADDR);
      // Prefetch pointer advances on its own
      GFX_RD_ADV <= 1'b1;
      @(posedge CLK_SYS);
      GFX_RD_ADV <= 1'b0;
      rd(cwp_pkg::CWP_IDX_GFX_X, {16'h0, a[15:0]});
      `CHK("lin_rd_adv", a, LIN_RD_ADDR);
      rd(8'h5b, 32'h0, 1'b1);
      repeat (2) @(posedge CLK_SYS);
      test_done();
   end
endmodule
